// file: inc/fpsi_map.svh
`ifndef FPSI_MAP_SVH
`define FPSI_MAP_SVH
`define FPSI_ADDR_CTRL 4'h0
`define FPSI_ADDR_STATUS 4'h4
`define FPSI_ADDR_LAMPS 4'h8
`define FPSI_CTRL_BOOT_WAIT 0
`define FPSI_CTRL_CFG_WARN 1
`define FPSI_CTRL_RESET 2'h0
`define FPSI_CLK_MHZ 100
`define FPSI_FLASH_HALF_MS 250
`define FPSI_REBOOT_HOLD_US 10
`define FPSI_REBOOT_HOLD_CYC (`FPSI_REBOOT_HOLD_US * `FPSI_CLK_MHZ)
`define FPSI_OVF_WINDOW_CYC 12'hFFF
`endif

// file: inc/fpsi_pkg.sv
package fpsi_pkg;
   typedef enum logic [1:0] {
      LAMP_OFF = 2'b00,
      LAMP_GREEN = 2'b01,
      LAMP_RED = 2'b10,
      LAMP_ORANGE = 2'b11
   } fpsi_lamp_t;
   typedef struct packed {
      logic streamPresent;
      logic streamValid;
      logic streamForeignType;
      logic serializerValid;
      logic hardwareFault;
      logic rearUnsuitable;
      logic syncInputPresent;
   } fpsi_cond_t;
   typedef struct packed {
      fpsi_lamp_t powerHealthLamp;
      fpsi_lamp_t displayStateLamp;
      fpsi_lamp_t unusedLampA;
      fpsi_lamp_t unusedLampB;
      fpsi_lamp_t streamInputLamp;
      fpsi_lamp_t serialOutputLamp;
      fpsi_lamp_t rearModuleLamp;
      fpsi_lamp_t inputFormatLamp;
      fpsi_lamp_t displayStateLampCopy;
      fpsi_lamp_t streamInputLampCopy;
      fpsi_lamp_t referenceInputLamp;
      fpsi_lamp_t overflowLamp;
   } fpsi_lamps_t;
endpackage

// file: rtl/fpsi_front_panel.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpsi_map.svh"
module fpsi_front_panel
   import fpsi_pkg::*;
#(
   parameter logic [24:0] FLASH_HALF_CYC = 25'(`FPSI_FLASH_HALF_MS * 1000 * `FPSI_CLK_MHZ)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic displaySwitchFront,
   input wire logic rebootButton,
   input wire fpsi_cond_t cond,
   input wire logic payloadByte,
   input wire logic nullByte,
   input wire logic outputSlot,
   input wire logic [9:0] converterData,
   input wire logic [9:0] displayData,
   output logic [9:0] serialOutData,
   output logic analogDisplayEnable,
   output logic cardReboot,
   output fpsi_lamps_t lamps
);

   logic ack;
   logic [1:0] ctrl;
   logic buttonPrev;
   logic rebootFire;
   logic [10:0] rebootCnt;
   logic localReset;
   logic [24:0] flashCnt;
   logic flashPhase;
   logic [11:0] windowCnt;
   logic [12:0] payloadCnt;
   logic [12:0] slotCnt;
   logic overflow;
   logic displayOn;
   logic running;
   logic notOperational;
   logic warning;
   fpsi_lamp_t next_power;
   fpsi_lamp_t next_stream;

   function automatic fpsi_lamp_t redIf(input logic bad);
      redIf = bad ? LAMP_RED : LAMP_GREEN;
   endfunction

   // bus slave: one wait cycle, answer at second edge
   assign waitrequest = (read | write) & ~ack;

   always_ff @(posedge clk) begin
      if (reset) begin
         ack <= 1'b0;
      end else begin
         ack <= (read | write) & ~ack;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         readdata <= 32'h0000_0000;
      end else if (read & ~ack) begin
         case (address)
            `FPSI_ADDR_CTRL: begin
               readdata <= {30'h0000_0000, ctrl};
            end
            `FPSI_ADDR_STATUS: begin
               readdata <= {20'h0_0000, displayOn, overflow, cardReboot, flashPhase, 1'b0, cond};
            end
            `FPSI_ADDR_LAMPS: begin
               readdata <= {8'h00, lamps};
            end
            default: begin
               readdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         ctrl <= `FPSI_CTRL_RESET;
      end else if (write & ack & byteenable[0] & (address == `FPSI_ADDR_CTRL)) begin
         ctrl <= writedata[1:0];
      end
   end

   // reboot button edge starts a held reboot pulse
   always_ff @(posedge clk) begin
      if (reset) begin
         buttonPrev <= 1'b0;
      end else begin
         buttonPrev <= rebootButton;
      end
   end

   assign rebootFire = rebootButton & ~buttonPrev & ~cardReboot;
   assign localReset = reset | rebootFire;

   always_ff @(posedge clk) begin
      if (reset) begin
         rebootCnt <= 11'h000;
         cardReboot <= 1'b0;
      end else if (rebootFire) begin
         rebootCnt <= 11'(`FPSI_REBOOT_HOLD_CYC - 1);
         cardReboot <= 1'b1;
      end else if (rebootCnt != 11'h000) begin
         rebootCnt <= rebootCnt - 11'h001;
      end else begin
         cardReboot <= 1'b0;
      end
   end

   // flash timebase
   always_ff @(posedge clk) begin
      if (localReset) begin
         flashCnt <= 25'h000_0000;
         flashPhase <= 1'b0;
      end else if (flashCnt >= FLASH_HALF_CYC - 25'h000_0001) begin
         flashCnt <= 25'h000_0000;
         flashPhase <= ~flashPhase;
      end else begin
         flashCnt <= flashCnt + 25'h000_0001;
      end
   end

   // bandwidth check over a fixed window
   always_ff @(posedge clk) begin
      if (localReset) begin
         windowCnt <= 12'h000;
         payloadCnt <= 13'h0000;
         slotCnt <= 13'h0000;
         overflow <= 1'b0;
      end else if (windowCnt == `FPSI_OVF_WINDOW_CYC) begin
         windowCnt <= 12'h000;
         payloadCnt <= 13'h0000;
         slotCnt <= 13'h0000;
         overflow <= payloadCnt > slotCnt;
      end else begin
         windowCnt <= windowCnt + 12'h001;
         payloadCnt <= payloadCnt + {12'h000, payloadByte & ~nullByte};
         slotCnt <= slotCnt + {12'h000, outputSlot};
      end
   end

   // output routing from the slide switch
   always_ff @(posedge clk) begin
      if (reset) begin
         displayOn <= 1'b0;
         analogDisplayEnable <= 1'b0;
         serialOutData <= 10'h000;
      end else begin
         displayOn <= displaySwitchFront;
         analogDisplayEnable <= displaySwitchFront;
         serialOutData <= displaySwitchFront ? displayData : converterData;
      end
   end

   assign running = cond.streamPresent & cond.streamValid;
   assign notOperational = ~running | cond.hardwareFault | cond.rearUnsuitable | cond.streamForeignType;
   assign warning = ctrl[`FPSI_CTRL_CFG_WARN] | overflow | ~cond.syncInputPresent;

   always_comb begin
      if (ctrl[`FPSI_CTRL_BOOT_WAIT]) begin
         next_power = flashPhase ? LAMP_GREEN : LAMP_OFF;
      end else if (notOperational | displayOn) begin
         next_power = LAMP_RED;
      end else if (warning) begin
         next_power = LAMP_ORANGE;
      end else begin
         next_power = LAMP_GREEN;
      end
   end

   always_comb begin
      if (running) begin
         next_stream = LAMP_GREEN;
      end else if (cond.streamPresent) begin
         next_stream = LAMP_RED;
      end else begin
         next_stream = flashPhase ? LAMP_RED : LAMP_OFF;
      end
   end

   // one register per lamp, gathered into the output struct below
   fpsi_lamp_t powerLamp;
   fpsi_lamp_t displayLamp;
   fpsi_lamp_t displayLampCopy;
   fpsi_lamp_t unusedA;
   fpsi_lamp_t unusedB;
   fpsi_lamp_t streamLamp;
   fpsi_lamp_t streamLampCopy;
   fpsi_lamp_t serialLamp;
   fpsi_lamp_t rearLamp;
   fpsi_lamp_t formatLamp;
   fpsi_lamp_t referenceLamp;
   fpsi_lamp_t ovfLamp;

   always_ff @(posedge clk) begin
      if (localReset) begin
         powerLamp <= LAMP_OFF;
      end else begin
         powerLamp <= next_power;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         displayLamp <= LAMP_OFF;
      end else begin
         displayLamp <= displayOn ? LAMP_RED : LAMP_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         displayLampCopy <= LAMP_OFF;
      end else begin
         displayLampCopy <= displayOn ? LAMP_RED : LAMP_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         unusedA <= LAMP_OFF;
      end else begin
         unusedA <= LAMP_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         unusedB <= LAMP_OFF;
      end else begin
         unusedB <= LAMP_OFF;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         streamLamp <= LAMP_OFF;
      end else begin
         streamLamp <= next_stream;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         streamLampCopy <= LAMP_OFF;
      end else begin
         streamLampCopy <= next_stream;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         serialLamp <= LAMP_OFF;
      end else begin
         serialLamp <= (cond.hardwareFault | ~cond.serializerValid) ? LAMP_RED : LAMP_GREEN;
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         rearLamp <= LAMP_OFF;
      end else begin
         rearLamp <= redIf(cond.rearUnsuitable);
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         formatLamp <= LAMP_OFF;
      end else begin
         formatLamp <= redIf(cond.streamForeignType);
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         referenceLamp <= LAMP_OFF;
      end else begin
         referenceLamp <= redIf(~cond.syncInputPresent);
      end
   end

   always_ff @(posedge clk) begin
      if (localReset) begin
         ovfLamp <= LAMP_OFF;
      end else begin
         ovfLamp <= redIf(overflow);
      end
   end

   assign lamps = '{
      powerHealthLamp: powerLamp,
      displayStateLamp: displayLamp,
      unusedLampA: unusedA,
      unusedLampB: unusedB,
      streamInputLamp: streamLamp,
      serialOutputLamp: serialLamp,
      rearModuleLamp: rearLamp,
      inputFormatLamp: formatLamp,
      displayStateLampCopy: displayLampCopy,
      streamInputLampCopy: streamLampCopy,
      referenceInputLamp: referenceLamp,
      overflowLamp: ovfLamp
   };

endmodule
`default_nettype wire

// file: verification/fpsi_front_panel_checker.sv
`timescale 1ns/1ps
`default_nettype none
module fpsi_front_panel_checker import fpsi_pkg::*; (
   input wire logic clk,
   input wire logic reset,
   input wire logic displaySwitchFront,
   input wire logic rebootButton,
   input wire fpsi_cond_t cond,
   input wire logic [9:0] converterData,
   input wire logic [9:0] displayData,
   input wire logic [9:0] serialOutData,
   input wire logic analogDisplayEnable,
   input wire logic cardReboot,
   input wire fpsi_lamps_t lamps
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_serial_mux: assert property (!$past(reset) |->
      serialOutData == ($past(displaySwitchFront) ? $past(displayData) : $past(converterData))) else $error("mux");
   a_analog_copy: assert property (!$past(reset) |->
      analogDisplayEnable == $past(displaySwitchFront)) else $error("analog");
   a_reboot_start: assert property ($rose(rebootButton) && !cardReboot |=> cardReboot) else $error("reboot");
   a_reboot_hold: assert property (!$past(reset) && $fell(cardReboot) |->
      $past(cardReboot, 999)) else $error("reboot short");
   a_unused_dark: assert property (lamps.unusedLampA == LAMP_OFF && lamps.unusedLampB == LAMP_OFF)
      else $error("unused lit");
   a_copy_lamps: assert property (lamps.displayStateLampCopy == lamps.displayStateLamp &&
      lamps.streamInputLampCopy == lamps.streamInputLamp) else $error("copy");
   a_display_lamp: assert property (!$past(reset) && !cardReboot |->
      lamps.displayStateLamp == ($past(analogDisplayEnable) ? LAMP_RED : LAMP_OFF)) else $error("display lamp");
   a_rear_lamp: assert property (!$past(reset) && !$past(reset, 2) && !cardReboot &&
      $past(cond.rearUnsuitable) == $past(cond.rearUnsuitable, 2) |->
      lamps.rearModuleLamp == ($past(cond.rearUnsuitable) ? LAMP_RED : LAMP_GREEN)) else $error("rear");
endmodule
bind fpsi_front_panel fpsi_front_panel_checker u_fpsi_front_panel_checker (.clk, .reset, .displaySwitchFront,
   .rebootButton, .cond, .converterData, .displayData, .serialOutData, .analogDisplayEnable, .cardReboot, .lamps);
`default_nettype wire

// file: verification/fpsi_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpsi_panel_model (
   input wire logic clk,
   input wire logic slideFront,
   input wire logic press,
   output logic displaySwitchFront,
   output logic rebootButton
);
   logic [2:0] held;
   initial begin
      displaySwitchFront = 1'b0;
      rebootButton = 1'b0;
      held = 3'h0;
   end
   // button stays down a few cycles per press
   always @(posedge clk) begin
      displaySwitchFront <= slideFront;
      held <= press ? 3'h4 : held - 3'(held != 3'h0);
      rebootButton <= press || held != 3'h0;
   end
endmodule
`default_nettype wire

// file: verification/fpsi_front_panel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fpsi_front_panel_tb_top import fpsi_pkg::*;;
   logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, slide = 1'b0, press = 1'b0;
   logic pb = 1'b0, nb = 1'b0, ob = 1'b1, swF, btn, ana, crb, wr;
   logic [3:0] addr = 4'h0;
   logic [31:0] wd = 32'h0, rd, q, obsV, rs = 32'hC861, expQ[$];
   logic [23:0] m;
   logic [9:0] cd = 10'h0, dd = 10'h0, so;
   fpsi_cond_t cond = 7'h0;
   fpsi_lamps_t lamps;
   int n_fail = 0, n_tests = 0;
   event obs;
   always #5 clk = ~clk;
   fpsi_front_panel #(.FLASH_HALF_CYC(25'h8)) u_fpsi_front_panel (.clk, .reset, .address(addr), .read, .write,
      .writedata(wd), .byteenable(4'hF), .readdata(rd), .waitrequest(wr), .displaySwitchFront(swF),
      .rebootButton(btn), .cond, .payloadByte(pb), .nullByte(nb), .outputSlot(ob), .converterData(cd),
      .displayData(dd), .serialOutData(so), .analogDisplayEnable(ana), .cardReboot(crb), .lamps);
   fpsi_panel_model u_fpsi_panel_model (.clk, .slideFront(slide), .press, .displaySwitchFront(swF),
      .rebootButton(btn));
   function logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function fpsi_lamps_t el(input fpsi_cond_t c, input logic d, input logic o);
      fpsi_lamps_t e;
      logic pv;
      pv = c.streamPresent & c.streamValid;
      e = '0;
      e.powerHealthLamp = (!pv | c.hardwareFault | c.rearUnsuitable | c.streamForeignType | d) ? LAMP_RED :
         (o | !c.syncInputPresent) ? LAMP_ORANGE : LAMP_GREEN;
      e.displayStateLamp = d ? LAMP_RED : LAMP_OFF;
      e.streamInputLamp = pv ? LAMP_GREEN : LAMP_RED;
      e.serialOutputLamp = (c.hardwareFault | !c.serializerValid) ? LAMP_RED : LAMP_GREEN;
      e.rearModuleLamp = c.rearUnsuitable ? LAMP_RED : LAMP_GREEN;
      e.inputFormatLamp = c.streamForeignType ? LAMP_RED : LAMP_GREEN;
      e.displayStateLampCopy = e.displayStateLamp;
      e.streamInputLampCopy = e.streamInputLamp;
      e.referenceInputLamp = c.syncInputPresent ? LAMP_GREEN : LAMP_RED;
      e.overflowLamp = o ? LAMP_RED : LAMP_GREEN;
      return e;
   endfunction
   task chk(input logic [31:0] e, input logic [31:0] g);
      expQ.push_back(e);
      obsV = g;
      ->obs;
      @(negedge clk);
   endtask
   always @(obs) begin
      n_tests++;
      if (obsV !== expQ[0]) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, obsV, expQ[0]);
      end
      void'(expQ.pop_front());
   end
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      read <= !w;
      write <= w;
      addr <= a;
      wd <= d;
      do @(posedge clk); while (wr !== 1'b0);
      q = rd;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task give_verdict;
      $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #300us;
      n_fail++;
      give_verdict;
   end
   initial begin
      logic [1:0] p0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      bus(1'b1, 4'h0, 32'h1);
      bus(1'b0, 4'h0, 32'h0);
      chk(32'h1, q);
      repeat (4) @(negedge clk);
      p0 = lamps.powerHealthLamp;
      repeat (8) @(negedge clk);
      chk(32'(LAMP_GREEN), 32'(p0 ^ lamps.powerHealthLamp));
      bus(1'b1, 4'hC, 32'h1);
      bus(1'b1, 4'h0, 32'h0);
      bus(1'b0, 4'hC, 32'h0);
      chk(32'h0, q);
      $display("test registers done");
      for (int i = 0; i < 24; i++) begin
         rs = xs(rs);
         @(posedge clk);
         {nb, pb, dd, cd, slide, cond} <= rs[29:0];
         repeat (4) @(negedge clk);
         m = cond.streamPresent ? 24'hFFFFFF : 24'hFF7FDF;
         chk(32'(el(cond, slide, 1'b0) & m), 32'(lamps & m));
         chk(32'(slide ? dd : cd), 32'(so));
         chk(32'(slide), 32'(ana));
      end
      $display("test lamps done");
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         {cond, slide, pb, nb, ob} <= {7'h69, 1'b0, 1'b1, j[0], 1'b0};
         repeat (8300) @(negedge clk);
         chk(32'(el(7'h69, 1'b0, !j[0])), 32'(lamps));
      end
      ob <= 1'b1;
      $display("test overflow done");
      @(posedge clk);
      press <= 1'b1;
      @(posedge clk);
      press <= 1'b0;
      repeat (5) @(negedge clk);
      chk(32'h1, 32'(crb));
      repeat (1010) @(negedge clk);
      chk(32'h0, 32'(crb));
      $display("test reboot done");
      give_verdict;
   end
endmodule
`default_nettype wire
